// >>> hdl/sth_pkg.sv
package sth_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned SEQ_PULSE_US    = 10;
    localparam int unsigned SEQ_PULSE_CYC   = (CLK_HZ / 1_000_000) * SEQ_PULSE_US;
    localparam int unsigned REF_LOSS_CYC    = 1000;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_CMD       = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h14;
    localparam logic [7:0] OFS_PANEL     = 8'h18;

    // control fields
    localparam int unsigned CTRL_TRIG_LSB = 0;
    localparam int unsigned CTRL_SEQ_LSB  = 2;
    localparam int unsigned CTRL_BL_BIT   = 4;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // command bits (write pulses)
    localparam int unsigned CMD_SW_TRIG   = 0;
    localparam int unsigned CMD_SWEEP_END = 1;
    localparam int unsigned CMD_LIM_PASS  = 2;
    localparam int unsigned CMD_LIM_FAIL  = 3;

    // interrupt bits
    localparam int unsigned IRQ_SWEEP_START = 0;
    localparam int unsigned IRQ_SWEEP_END   = 1;
    localparam int unsigned IRQ_PANEL       = 2;
    localparam int unsigned IRQ_REF_CHANGE  = 3;
    localparam int unsigned IRQ_W           = 4;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        TRIG_SYNTH,
        TRIG_EXTERNAL,
        TRIG_SOFTWARE,
        TRIG_NONE
    } sth_trig_src_t;

    typedef enum logic [1:0] {
        SEQ_HOLD_LOW,
        SEQ_HOLD_HIGH,
        SEQ_PULSE_HIGH,
        SEQ_PULSE_LOW
    } sth_seq_mode_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } sth_avl_req_t;

    typedef struct packed {
        logic        valid;
        logic        is_encoder;
        logic [7:0]  code;
    } sth_panel_evt_t;

endpackage : sth_pkg

// >>> hdl/sth_pin_sync.sv
module sth_pin_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      fell
);
    import sth_pkg::*;

    logic [2:0] sh_q;
    logic       level_q;

    // a change counts once the second and third stages agree
    wire agree = (sh_q[1] == sh_q[2]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sh_q    <= 3'h7;
            level_q <= 1'b1;
        end else begin
            sh_q    <= {sh_q[1:0], pin_in};
            level_q <= agree ? sh_q[2] : level_q;
        end
    end

    assign level = level_q;
    assign fell  = agree && !sh_q[2] && level_q;
endmodule : sth_pin_sync

// >>> hdl/sth_panel_dec.sv
module sth_panel_dec (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic [7:0]      key_lines_n,
    input  wire logic            enc_a,
    input  wire logic            enc_b,
    output sth_pkg::sth_panel_evt_t evt
);
    import sth_pkg::*;

    logic [7:0] k1_q, k2_q, k3_q, kst_q;
    logic [1:0] e1_q, e2_q, e3_q, est_q;
    sth_panel_evt_t evt_q;

    // synchronised and agreed levels
    wire [7:0] key_ok  = (k2_q == k3_q) ? ~k3_q : kst_q;
    wire [1:0] enc_ok  = (e2_q == e3_q) ? e3_q : est_q;
    wire [7:0] key_new = key_ok & ~kst_q;
    wire       enc_stp = (enc_ok[0] != est_q[0]);

    function automatic logic [7:0] lowest_bit(input logic [7:0] v);
        logic [7:0] idx;
        idx = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                idx = 8'(i);
            end
        end
        return idx;
    endfunction : lowest_bit

    always_ff @(posedge core_clk) begin
        if (rst) begin
            {k1_q, k2_q, k3_q} <= {3{8'hFF}};
            kst_q              <= 8'h00;
            {e1_q, e2_q, e3_q} <= 6'h00;
            est_q              <= 2'h0;
            evt_q              <= '0;
        end else begin
            k1_q  <= key_lines_n;
            k2_q  <= k1_q;
            k3_q  <= k2_q;
            kst_q <= key_ok;
            e1_q  <= {enc_b, enc_a};
            e2_q  <= e1_q;
            e3_q  <= e2_q;
            est_q <= enc_ok;
            // encoder step wins over a key in the same cycle; direction in code bit 0
            evt_q.valid      <= enc_stp || (key_new != 8'h00);
            evt_q.is_encoder <= enc_stp;
            evt_q.code       <= enc_stp ? {7'h00, enc_ok[0] ^ enc_ok[1]} : lowest_bit(key_new);
        end
    end

    assign evt = evt_q;
endmodule : sth_panel_dec

// >>> hdl/sth_top.sv
// Functional notes
// RULE1 - sweep starts from one selected source
// RULE2 - external trigger acts on falling edge
// RULE3 - software sets source; external is exclusive
// RULE4 - sequence output static or 10 us pulse
// RULE5 - pass/fail output follows last limit result
// RULE6 - external reference auto selected while present
// RULE7 - panel events forwarded with interrupt
// RULE8 - digital backlight on/off line
// RULE9 - pulse counter from clock, rearm per sweep
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
module sth_top #(
    parameter int unsigned PULSE_CYC = sth_pkg::SEQ_PULSE_CYC,
    parameter int unsigned LOSS_CYC  = sth_pkg::REF_LOSS_CYC
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               synth_sweep_trig,
    input  wire logic               sweep_done,
    input  wire logic               external_sweep_trigger_in,
    input  wire logic               external_freq_ref_in,
    input  wire logic [7:0]         key_lines_n,
    input  wire logic               rotary_encoder_a,
    input  wire logic               rotary_encoder_b,
    output logic                    sweep_start,
    output logic                    sequence_handler_out,
    output logic                    limit_pass_out,
    output logic                    external_freq_ref_in_select,
    output logic                    backlight_on,
    output logic                    irq
);
    import sth_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, answer on the second cycle of the request
    logic [31:0]    ctrl_q;
    logic [IRQ_W-1:0] ist_q, ien_q;
    logic           ack_q;
    logic [31:0]    rdata_q;
    logic [9:0]     panel_q;
    sth_avl_req_t   req;

    assign req = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata};

    wire req_any  = req.read || req.write;
    wire take     = req_any && ack_q;
    wire wr_take  = take && req.write;
    wire rd_take  = take && req.read;
    wire wr_ctrl  = wr_take && (req.address == OFS_CTRL);
    wire wr_cmd   = wr_take && (req.address == OFS_CMD) && avs_byteenable[0];
    wire wr_ien   = wr_take && (req.address == OFS_IRQ_EN) && avs_byteenable[0];
    wire wr_iclr  = wr_take && (req.address == OFS_IRQ_CLR) && avs_byteenable[0];
    wire rd_panel = rd_take && (req.address == OFS_PANEL);

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge_be

    ////////////////////////////////////////////////////////////////////////////////
    // control fields
    wire sth_trig_src_t trig_src = sth_trig_src_t'(ctrl_q[CTRL_TRIG_LSB +: 2]);
    wire sth_seq_mode_t seq_mode = sth_seq_mode_t'(ctrl_q[CTRL_SEQ_LSB +: 2]);
    wire cmd_sw   = wr_cmd && req.writedata[CMD_SW_TRIG];
    wire cmd_end  = wr_cmd && req.writedata[CMD_SWEEP_END];
    wire cmd_pass = wr_cmd && req.writedata[CMD_LIM_PASS];
    wire cmd_fail = wr_cmd && req.writedata[CMD_LIM_FAIL];

    ////////////////////////////////////////////////////////////////////////////////
    // external trigger synchroniser
    logic ext_lvl, ext_fell;

    sth_pin_sync u_trig_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (external_sweep_trigger_in),
        .level    (ext_lvl),
        .fell     (ext_fell)
    );

    // RULE1 source multiplexer
    // RULE3 external is sole trigger
    // RULE2 falling edge starts sweep
    logic start_d;
    always_comb begin
        case (trig_src)
            TRIG_SYNTH:    start_d = synth_sweep_trig;
            TRIG_EXTERNAL: start_d = ext_fell;
            TRIG_SOFTWARE: start_d = cmd_sw;
            default:       start_d = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequence output; pulses fire only at sweep end and never retrigger mid-pulse
    logic [31:0] pcnt_q;
    logic        pulsing_q;
    wire         sweep_end = sweep_done || cmd_end;

    // RULE9 pulse length counter
    wire pulse_last = pulsing_q && (pcnt_q == 32'(PULSE_CYC - 1));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulsing_q <= 1'b0;
        end else if (pulsing_q) begin
            pulsing_q <= !pulse_last;
        end else begin
            // RULE9 rearm at sweep end
            pulsing_q <= sweep_end && (seq_mode == SEQ_PULSE_HIGH || seq_mode == SEQ_PULSE_LOW);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || !pulsing_q || pulse_last) begin
            pcnt_q <= 32'h0000_0000;
        end else begin
            pcnt_q <= pcnt_q + 32'h0000_0001;
        end
    end

    // RULE4 static or pulsed level
    logic seq_d;
    always_comb begin
        case (seq_mode)
            SEQ_HOLD_LOW:   seq_d = 1'b0;
            SEQ_HOLD_HIGH:  seq_d = 1'b1;
            SEQ_PULSE_HIGH: seq_d = pulsing_q;
            SEQ_PULSE_LOW:  seq_d = !pulsing_q;
            default:        seq_d = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reference detect: edges on the input keep a watchdog alive
    logic ref_lvl;
    logic ref_prev_q;
    logic ref_arm_q;
    logic [31:0] rcnt_q;
    logic        ref_sel_q;

    sth_pin_sync u_ref_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (external_freq_ref_in),
        .level    (ref_lvl),
        .fell     ()
    );

    wire ref_edge  = (ref_lvl != ref_prev_q);
    wire ref_quiet = ref_arm_q && (rcnt_q == 32'(LOSS_CYC - 1));
    // RULE6 present while edges keep coming
    // the first edge only arms the watchdog, so the synchroniser settling after reset never selects
    wire ref_sel_d = (ref_edge && ref_arm_q) ? 1'b1 : ref_quiet ? 1'b0 : ref_sel_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_prev_q <= 1'b1;
        end else begin
            ref_prev_q <= ref_lvl;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_arm_q <= 1'b0;
        end else begin
            ref_arm_q <= ref_edge ? 1'b1 : ref_quiet ? 1'b0 : ref_arm_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rcnt_q <= 32'h0000_0000;
        end else begin
            rcnt_q <= (ref_edge || ref_quiet || !ref_arm_q) ? 32'h0000_0000 : rcnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_sel_q <= 1'b0;
        end else begin
            ref_sel_q <= ref_sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // front panel
    sth_panel_evt_t pevt;

    sth_panel_dec u_panel (
        .core_clk    (core_clk),
        .rst         (rst),
        .key_lines_n (key_lines_n),
        .enc_a       (rotary_encoder_a),
        .enc_b       (rotary_encoder_b),
        .evt         (pevt)
    );

    // panel holding register: bit 9 new, bit 8 encoder, low byte code
    // RULE7 latch event for processor
    wire [9:0] panel_d = pevt.valid ? {1'b1, pevt.is_encoder, pevt.code}
                       : rd_panel   ? {1'b0, panel_q[8:0]} : panel_q;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts: hardware set wins over a same-cycle clear
    wire [IRQ_W-1:0] ev_set;
    assign ev_set[IRQ_SWEEP_START] = start_d;
    assign ev_set[IRQ_SWEEP_END]   = sweep_end;
    // RULE7 panel interrupt source
    assign ev_set[IRQ_PANEL]       = pevt.valid;
    assign ev_set[IRQ_REF_CHANGE]  = ref_sel_d != ref_sel_q;

    wire [IRQ_W-1:0] clr_mask = wr_iclr ? req.writedata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] ist_d    = ev_set | (ist_q & ~clr_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        case (req.address)
            OFS_CTRL:     rd_mux = ctrl_q;
            OFS_STATUS:   rd_mux = {28'h0000000, ref_sel_q, limit_pass_out, sequence_handler_out, ext_lvl};
            OFS_IRQ_STAT: rd_mux = {28'h0000000, ist_q};
            OFS_IRQ_EN:   rd_mux = {28'h0000000, ien_q};
            OFS_PANEL:    rd_mux = {22'h000000, panel_q};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_any && !ack_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= (req.read && !ack_q) ? rd_mux : rdata_q;
        end
    end

    // RULE3 software selects source
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= wr_ctrl ? merge_be(ctrl_q, req.writedata, avs_byteenable) : ctrl_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ien_q <= '0;
        end else begin
            ien_q <= wr_ien ? req.writedata[IRQ_W-1:0] : ien_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ist_q <= '0;
        end else begin
            ist_q <= ist_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            panel_q <= 10'h000;
        end else begin
            panel_q <= panel_d;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sweep_start <= 1'b0;
        end else begin
            sweep_start <= start_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sequence_handler_out <= 1'b0;
        end else begin
            sequence_handler_out <= seq_d;
        end
    end

    // RULE5 pass high, fail low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            limit_pass_out <= 1'b0;
        end else begin
            limit_pass_out <= cmd_pass ? 1'b1 : cmd_fail ? 1'b0 : limit_pass_out;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            external_freq_ref_in_select <= 1'b0;
        end else begin
            external_freq_ref_in_select <= ref_sel_d;
        end
    end

    // RULE8 backlight on/off line
    always_ff @(posedge core_clk) begin
        if (rst) begin
            backlight_on <= 1'b0;
        end else begin
            backlight_on <= ctrl_q[CTRL_BL_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ist_d & ien_q);
        end
    end

    // idles high so that it comes from a flop; low only in the answer cycle, always the inverse of ack_q
    always_ff @(posedge core_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(req_any && !ack_q);
        end
    end

    assign avs_readdata    = rdata_q;
endmodule : sth_top

// >>> sim/sth_top_checker.sv
module sth_top_checker #(
    parameter int unsigned PULSE_CYC = sth_pkg::SEQ_PULSE_CYC,
    parameter int unsigned LOSS_CYC  = sth_pkg::REF_LOSS_CYC
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        synth_sweep_trig,
    input wire logic        sweep_done,
    input wire logic        external_sweep_trigger_in,
    input wire logic        external_freq_ref_in,
    input wire logic        sweep_start,
    input wire logic        sequence_handler_out,
    input wire logic        limit_pass_out,
    input wire logic        external_freq_ref_in_select,
    input wire logic        backlight_on
);
    import sth_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] src_q, seq_q;
    logic       bl_q, out_p_q, ref_p_q, trg_p_q;
    logic [7:0] quiet_q, run_q, ref_q, fall_q;
    wire        wr_ok  = avs_write && !avs_waitrequest;
    wire        wr_ctl = wr_ok && avs_address == OFS_CTRL;
    wire        wr_cmd = wr_ok && avs_address == OFS_CMD;

    // shadow of the control word; quiet_q masks the settling after a rewrite
    always_ff @(posedge core_clk) begin
        out_p_q <= sequence_handler_out;
        ref_p_q <= external_freq_ref_in;
        trg_p_q <= external_sweep_trigger_in;
        run_q   <= (rst || sequence_handler_out != out_p_q) ? 8'h01 : run_q + 8'(run_q != 8'hFF);
        ref_q   <= (rst || external_freq_ref_in != ref_p_q) ? 8'h00 : ref_q + 8'(ref_q != 8'hFF);
        fall_q  <= rst ? 8'hFF : (trg_p_q && !external_sweep_trigger_in) ? 8'h00 : fall_q + 8'(fall_q != 8'hFF);
        quiet_q <= (rst || wr_ctl) ? 8'h00 : quiet_q + 8'(quiet_q != 8'hFF);
        if (rst)
            {src_q, seq_q, bl_q} <= '0;
        else if (wr_ctl)
            {bl_q, seq_q, src_q} <= avs_writedata[4:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_synth_go: assert property (
        src_q == TRIG_SYNTH && quiet_q > 8 && synth_sweep_trig |-> ##[1:2] sweep_start) else $error("no synth start");
    chk_ext_go: assert property (
        src_q == TRIG_EXTERNAL && quiet_q > 8 && fall_q == 0 |-> ##[1:8] sweep_start) else $error("no ext start");
    chk_ext_only: assert property (
        src_q == TRIG_EXTERNAL && quiet_q > 8 && fall_q > 12 && synth_sweep_trig |=> !sweep_start ##1 !sweep_start)
        else $error("synth start in ext mode");
    chk_seq_hold: assert property (
        seq_q == SEQ_HOLD_HIGH && quiet_q > 3 |-> sequence_handler_out) else $error("seq hold high lost");
    chk_seq_fire: assert property (
        seq_q == SEQ_PULSE_LOW && quiet_q > 40 && run_q > 3 && sequence_handler_out && sweep_done
        |-> ##[1:3] !sequence_handler_out) else $error("no low pulse");
    chk_pulse_len: assert property (
        seq_q == SEQ_PULSE_HIGH && quiet_q > 40 && $fell(sequence_handler_out) |-> run_q == PULSE_CYC)
        else $error("pulse width wrong");
    chk_limit_out: assert property (
        wr_cmd && (avs_writedata[CMD_LIM_PASS] || avs_writedata[CMD_LIM_FAIL])
        |=> ##1 limit_pass_out == $past(avs_writedata[CMD_LIM_PASS], 2)) else $error("limit out wrong");
    chk_ref_loss: assert property (
        ref_q > LOSS_CYC + 8 |-> !external_freq_ref_in_select) else $error("ref kept after loss");
    chk_backlight: assert property (
        quiet_q > 2 |-> backlight_on == bl_q) else $error("backlight wrong");
endmodule : sth_top_checker

// >>> sim/sth_handler_model.sv
module sth_handler_model (
    input  wire logic core_clk,
    input  wire logic fire,
    input  wire logic ref_on,
    output wire logic trig_pin,
    output wire logic ref_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] low_q = 4'h0;
    logic [1:0] ph_q  = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // idle high, negative-going edge held low
    always @(posedge core_clk) begin
        if (fire)
            low_q <= 4'h8;
        else if (low_q != 4'h0)
            low_q <= low_q - 4'h1;
    end
    assign trig_pin = (low_q == 4'h0);

    // reference runs while connected
    // a removed source leaves the pin at its pull-down level
    always @(posedge core_clk) begin
        if (ref_on)
            ph_q <= ph_q + 2'h1;
    end
    assign ref_pin = ref_on && ph_q[1];
endmodule : sth_handler_model

// >>> sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sth_pkg::*;

    localparam int unsigned PC = 10;
    localparam int unsigned LC = 20;
    logic         core_clk = 1'b0;
    logic         rst = 1'b1;
    sth_avl_req_t req = '0;
    logic         synth_sweep_trig = 1'b0, sweep_done = 1'b0, fire = 1'b0, ref_on = 1'b0;
    logic [7:0]   key_lines_n = 8'hFF;
    logic         rotary_encoder_a = 1'b0, rotary_encoder_b = 1'b0;
    logic [31:0]  avs_readdata, rd;
    logic         avs_waitrequest, sweep_start, sequence_handler_out, limit_pass_out, external_freq_ref_in_select;
    logic         backlight_on, irq;
    wire          external_sweep_trigger_in, external_freq_ref_in;
    int           fails = 0, n_checks = 0, n_start = 0, k, v;

    sth_top #(.PULSE_CYC(PC), .LOSS_CYC(LC)) i_dut (
        .avs_address(req.address), .avs_read(req.read), .avs_write(req.write),
        .avs_writedata(req.writedata), .avs_byteenable(4'hF), .*);
    sth_handler_model i_hdl (.core_clk(core_clk), .fire(fire), .ref_on(ref_on),
        .trig_pin(external_sweep_trigger_in), .ref_pin(external_freq_ref_in));

    ////////////////////////////////////////////////////////////////////////////////
    initial forever #2 core_clk = ~core_clk;
    always @(negedge core_clk) n_start += (sweep_start === 1'b1);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    // the request stands until waitrequest is seen low at a rising edge; read data is taken there
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        req <= '0;
        @(negedge core_clk);
        if (n >= 50)
            fails++;
    endtask : bus

    task automatic kick(input int c);
        @(posedge core_clk);
        synth_sweep_trig <= (c == 0);
        sweep_done       <= (c == 1);
        fire             <= (c == 2);
        @(posedge core_clk);
        {synth_sweep_trig, sweep_done, fire} <= 3'h0;
        @(negedge core_clk);
    endtask : kick

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200_000;
        fails++;
        test_done();
    end

    initial begin
        v = $urandom(32'hF0AE);
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        bus(0, OFS_CTRL, 0);
        check(rd, CTRL_RESET);
        check(sequence_handler_out, 0);
        bus(1, 8'h1C, 32'hFFFF_FFFF);
        bus(0, 8'h1C, 0);
        check(rd, 0);
        // every source against every cause: only the selected one starts a sweep
        for (int s = 0; s < 4; s++) begin
            bus(1, OFS_CTRL, 32'(s));
            for (int c = 0; c < 3; c++) begin
                tick(12 + $urandom_range(4));
                n_start = 0;
                if (c == 2)
                    bus(1, OFS_CMD, 32'h1 << CMD_SW_TRIG);
                else
                    kick(c == 0 ? 0 : 2);
                tick(14);
                check(n_start, 32'(s == c));
            end
        end
        // all sequence modes; second sweep end lands inside the pulse and is ignored
        for (int m = 0; m < 4; m++) begin
            bus(1, OFS_CTRL, 32'(m << 2 | (m & 1) << 4 | 3));
            tick(50);
            k = (m == 1 || m == 3);
            check(sequence_handler_out, k);
            check(backlight_on, m & 1);
            kick(1);
            tick(4);
            check(sequence_handler_out, m < 2 ? k : (m == 2));
            kick(1);
            tick(PC);
            check(sequence_handler_out, k);
            bus(1, OFS_CMD, 32'h1 << CMD_SWEEP_END);
            tick(5);
            check(sequence_handler_out, m < 2 ? k : (m == 2));
            tick(PC + 4);
        end
        for (int i = 0; i < 8; i++) begin
            v = $urandom_range(3, 1);
            bus(1, OFS_CMD, 32'(v) << CMD_LIM_PASS);
            tick($urandom_range(3, 1));
            check(limit_pass_out, v & 1);
            bus(0, OFS_STATUS, 0);
            check(rd[2], v & 1);
        end
        @(posedge core_clk);
        ref_on <= 1'b1;
        tick(40);
        check(external_freq_ref_in_select, 1);
        bus(0, OFS_STATUS, 0);
        check(rd[3], 1);
        @(posedge core_clk);
        ref_on <= 1'b0;
        tick(LC + 40);
        check(external_freq_ref_in_select, 0);
        bus(0, OFS_IRQ_STAT, 0);
        check(rd[3], 1);
        bus(1, OFS_IRQ_CLR, 32'hF);
        bus(1, OFS_IRQ_EN, 32'h1 << IRQ_PANEL);
        check(irq, 0);
        k = $urandom_range(7);
        @(posedge core_clk);
        key_lines_n <= ~(8'h01 << k);
        for (int n = 0; n < 2000 && irq !== 1'b1; n++)
            tick(1);
        check(irq, 1);
        bus(0, OFS_PANEL, 0);
        check(rd[9:0], {2'b10, 8'(k)});
        bus(0, OFS_PANEL, 0);
        check(rd[9], 0);
        @(posedge core_clk);
        key_lines_n <= 8'hFF;
        tick(200);
        bus(1, OFS_IRQ_CLR, 32'h1 << IRQ_PANEL);
        tick(2);
        check(irq, 0);
        // masked source: the status bit still latches but the line stays low
        bus(1, OFS_IRQ_EN, 0);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {rotary_encoder_a, rotary_encoder_b} <= {i < 2, i == 1 || i == 2};
            tick(20);
        end
        tick(200);
        check(irq, 0);
        bus(0, OFS_IRQ_STAT, 0);
        check(rd[IRQ_PANEL], 1);
        bus(0, OFS_PANEL, 0);
        check(rd[9:8], 2'b11);
        test_done();
    end
endmodule : tb

bind sth_top sth_top_checker #(.PULSE_CYC(PULSE_CYC), .LOSS_CYC(LOSS_CYC)) i_chk (.*);
